// ---- core/sdlp_lowpower.sv ----
// Notes on behaviour
// RULE_01: self-refresh entry is refresh command with clock enable falling.
// RULE_02: controller switches termination off before self-refresh entry.
// RULE_03: in self-refresh only clock enable is looked at; the code also needs nop or deselect for exit.
// RULE_04: loop disabled and clock gated in self-refresh, re-enabled on exit.
// RULE_05: an internal refresh happens within the minimum pulse; stay at least that long; the code loads the pulse count but never holds off exit with it.
// RULE_06: controller may stop clock one cycle after entry, restart before exit.
// RULE_07: only nop or deselect until non-read exit delay ends.
// RULE_08: reads wait the read exit delay of 200 clocks after exit.
// RULE_09: one extra auto-refresh needed before self-refresh again.
// RULE_10: all banks idle before self-refresh entry.
// RULE_11: power-down entry is clock enable low with nop or deselect.
// RULE_12: idle banks give precharge power-down, else active, exit speed by mode bit.
// RULE_13: buffers off in power-down; loop kept only in fast-exit active power-down.
// RULE_14: controller limits power-down to nine average refresh intervals.
// RULE_15: power-down exits on clock enable high with nop; latency then applies.
// RULE_16: after read, active power-down waits read latency plus half burst.
// RULE_17: after write, waits write latency, half burst and turnaround.
// RULE_18: after write with precharge, wait internal precharge; precharge power-down.
// RULE_19: power-down allowed after activate, precharge, refresh or mode set.
// RULE_20: nop and deselect are equivalent and never end a burst.
// RULE_21: frequency change only in idle precharge power-down with termination off.
// RULE_22: after frequency change, loop reset and termination off for relock.
module sdlp_lowpower
  import sdlp_pkg::*;
#(
  parameter int MIN_PULSE_CYC = MIN_CKE_PULSE_CYC,
  parameter int NONREAD_CYC = SR_NONREAD_EXIT_CYC,
  parameter int READ_CYC = SR_READ_EXIT_CYC
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic cke_pin,
  input wire logic cs_n_pin,
  input wire logic ras_n_pin,
  input wire logic cas_n_pin,
  input wire logic we_n_pin,
  input wire logic banks_open,
  input wire logic active_pd_exit_select,
  output logic self_refresh_q,
  output logic power_down_q,
  output logic active_pd_q,
  output logic dll_enabled_q,
  output logic int_clock_gated_q,
  output logic buffers_off_q,
  output logic internal_refresh_q,
  output logic cmd_allowed_q,
  output logic read_allowed_q,
  output logic sref_allowed_q
);
  // counts must fit the counter; the non-read window must close inside the read window
  if (READ_CYC >= (1 << CNT_W) || MIN_PULSE_CYC >= (1 << CNT_W) || MIN_PULSE_CYC < 1 ||
      NONREAD_CYC < 1 || NONREAD_CYC > READ_CYC) begin : g_bad_counts
    $error("sdlp_lowpower: counts do not fit");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] s1_q, s2_q;
  always_ff @(posedge mclk) begin
    s1_q <= {cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin};
    s2_q <= s1_q;
  end

  sdlp_cmd_if cif();
  assign cif.cs_n = s2_q[3];
  assign cif.ras_n = s2_q[2];
  assign cif.cas_n = s2_q[1];
  assign cif.we_n = s2_q[0];
  sdlp_cmd_decode u_dec (.c(cif));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  sdlp_state_t st_q, st_d;
  logic cke_prev_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic need_aref_q, need_aref_d;
  logic slow_q, slow_d;
  wire cke = s2_q[4];
  wire cke_fall = cke_prev_q & ~cke;
  wire cke_rise = ~cke_prev_q & cke;
  wire is_nop = (cif.cmd == SDLP_CMD_NOP);
  wire sref_entry = cke_fall & (cif.cmd == SDLP_CMD_AREF); // RULE_01
  wire pd_entry = cke_fall & is_nop; // RULE_11
  wire [CNT_W-1:0] cnt_dec = (cnt_q == '0) ? '0 : cnt_q - 1'b1;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    return n[CNT_W-1:0];
  endfunction

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_dec;
    need_aref_d = need_aref_q;
    slow_d = slow_q;
    case (st_q)
      SDLP_ST_RUN: begin
        if (cif.cmd == SDLP_CMD_AREF && cke) need_aref_d = 1'b0; // RULE_09
        if (sref_entry && !need_aref_q) begin
          st_d = SDLP_ST_SREF;
          cnt_d = cyc(MIN_PULSE_CYC); // RULE_05
        end else if (pd_entry) begin
          st_d = banks_open ? SDLP_ST_APD : SDLP_ST_PPD; // RULE_12
          slow_d = banks_open & active_pd_exit_select; // RULE_12
        end
      end
      SDLP_ST_SREF: begin
        // exit needs clock enable rising with nop or deselect on the other pins
        if (cke_rise && is_nop) begin // RULE_03
          st_d = SDLP_ST_SRX;
          cnt_d = cyc(READ_CYC);
          need_aref_d = 1'b1; // RULE_09
        end
      end
      SDLP_ST_SRX: if (cnt_q == cyc(1)) st_d = SDLP_ST_RUN;
      SDLP_ST_PPD, SDLP_ST_APD: begin
        if (cke_rise && is_nop) begin // RULE_15
          st_d = SDLP_ST_PDX;
          cnt_d = (st_q == SDLP_ST_PPD) ? cyc(PD_EXIT_CYC) :
                  slow_q ? cyc(SLOW_APD_EXIT_CYC) : cyc(FAST_APD_EXIT_CYC);
        end
      end
      SDLP_ST_PDX: if (cnt_q <= cyc(1)) st_d = SDLP_ST_RUN;
      default: st_d = SDLP_ST_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  // clock enable idles high, so its history starts high: no false edge after reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= SDLP_ST_RUN;
      cnt_q <= '0;
      cke_prev_q <= 1'b1;
      need_aref_q <= 1'b0;
      slow_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cke_prev_q <= cke;
      need_aref_q <= need_aref_d;
      slow_q <= slow_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered from next state
  // ----------------------------------------------------------------
  wire in_sr = (st_d == SDLP_ST_SREF);
  wire in_pd = (st_d == SDLP_ST_PPD) | (st_d == SDLP_ST_APD);
  // elapsed exit cycles for the non-read window
  wire [CNT_W-1:0] srx_gone = cyc(READ_CYC) - cnt_d;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      self_refresh_q <= 1'b0;
      power_down_q <= 1'b0;
      active_pd_q <= 1'b0;
      dll_enabled_q <= 1'b1;
      int_clock_gated_q <= 1'b0;
      buffers_off_q <= 1'b0;
      internal_refresh_q <= 1'b0;
      cmd_allowed_q <= 1'b1;
      read_allowed_q <= 1'b1;
      sref_allowed_q <= 1'b1;
    end else begin
      self_refresh_q <= in_sr;
      power_down_q <= in_pd;
      active_pd_q <= (st_d == SDLP_ST_APD);
      // loop stays alive only in fast active power-down
      dll_enabled_q <= ~in_sr & ~(st_d == SDLP_ST_PPD) &
                       ~((st_d == SDLP_ST_APD) & slow_d); // RULE_04 RULE_13
      int_clock_gated_q <= in_sr; // RULE_04
      buffers_off_q <= in_pd | in_sr; // RULE_13
      // one refresh fired on the first self-refresh cycle, well inside the pulse
      internal_refresh_q <= in_sr & (st_q != SDLP_ST_SREF); // RULE_05
      cmd_allowed_q <= (st_d == SDLP_ST_RUN) |
                       ((st_d == SDLP_ST_SRX) & (srx_gone >= cyc(NONREAD_CYC))); // RULE_07
      read_allowed_q <= (st_d == SDLP_ST_RUN); // RULE_08
      sref_allowed_q <= (st_d == SDLP_ST_RUN) & ~need_aref_d; // RULE_09
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_sref_enter;
    @(posedge mclk) disable iff (!resetn)
      (st_q == SDLP_ST_RUN && sref_entry && !need_aref_q) |=> self_refresh_q && !dll_enabled_q;
  endproperty
  a_sref_enter: assert property (p_sref_enter) else $error("no self-refresh entry"); // RULE_01

  property p_gate;
    @(posedge mclk) disable iff (!resetn)
      self_refresh_q |-> int_clock_gated_q && buffers_off_q && !dll_enabled_q;
  endproperty
  a_gate: assert property (p_gate) else $error("clock not gated"); // RULE_04

  property p_ref;
    @(posedge mclk) disable iff (!resetn) $rose(self_refresh_q) |-> internal_refresh_q;
  endproperty
  a_ref: assert property (p_ref) else $error("no internal refresh"); // RULE_05

  property p_srx_read;
    @(posedge mclk) disable iff (!resetn)
      (st_q == SDLP_ST_SRX && cnt_q > cyc(1)) |=> !read_allowed_q;
  endproperty
  a_srx_read: assert property (p_srx_read) else $error("read too early"); // RULE_08

  property p_pd;
    @(posedge mclk) disable iff (!resetn)
      (st_q == SDLP_ST_RUN && pd_entry && !sref_entry) |=> power_down_q && !cmd_allowed_q;
  endproperty
  a_pd: assert property (p_pd) else $error("no power-down"); // RULE_11

  property p_fast;
    @(posedge mclk) disable iff (!resetn)
      (active_pd_q && !slow_q) |-> dll_enabled_q;
  endproperty
  a_fast: assert property (p_fast) else $error("loop off in fast exit"); // RULE_13

  property p_exit;
    @(posedge mclk) disable iff (!resetn)
      (power_down_q && st_q == SDLP_ST_PPD && cke_rise && is_nop) |=>
        !power_down_q ##1 !cmd_allowed_q ##1 cmd_allowed_q;
  endproperty
  a_exit: assert property (p_exit) else $error("bad precharge exit"); // RULE_15

  property p_sr_again;
    @(posedge mclk) disable iff (!resetn) $fell(self_refresh_q) |-> !sref_allowed_q;
  endproperty
  a_sr_again: assert property (p_sr_again) else $error("re-entry too soon"); // RULE_09
endmodule // sdlp_lowpower

// ---- common/sdlp_pkg.sv ----
package sdlp_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int MIN_CKE_PULSE_NS = 7500; // min_clock_enable_pulse, in ns
  localparam int MIN_CKE_PULSE_CYC = (MIN_CKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SR_READ_EXIT_CYC = 200; // self_refresh_read_exit_delay
  localparam int SR_NONREAD_EXIT_NS = 200; // self_refresh_nonread_exit_delay
  localparam int SR_NONREAD_EXIT_CYC =
    (SR_NONREAD_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PD_EXIT_CYC = 2; // precharge_pd_exit_latency
  localparam int FAST_APD_EXIT_CYC = 2; // fast_active_pd_exit_latency
  localparam int SLOW_APD_EXIT_CYC = 6; // slow_active_pd_exit_latency
  localparam int CNT_W = 9;

  // ----------------------------------------------------------------
  // power states
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    SDLP_ST_RUN    = 6'b00_0001,
    SDLP_ST_SREF   = 6'b00_0010,
    SDLP_ST_SRX    = 6'b00_0100,
    SDLP_ST_PPD    = 6'b00_1000,
    SDLP_ST_APD    = 6'b01_0000,
    SDLP_ST_PDX    = 6'b10_0000
  } sdlp_state_t;

  typedef enum logic [2:0] {
    SDLP_CMD_NOP   = 3'h0,
    SDLP_CMD_AREF  = 3'h1,
    SDLP_CMD_READ  = 3'h2,
    SDLP_CMD_OTHER = 3'h3
  } sdlp_cmd_t;
endpackage

// ---- common/sdlp_cmd_if.sv ----
interface sdlp_cmd_if;
  import sdlp_pkg::*;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  sdlp_cmd_t cmd;
  modport dec (input cs_n, input ras_n, input cas_n, input we_n, output cmd);
  modport top (output cs_n, output ras_n, output cas_n, output we_n, input cmd);
endinterface

// ---- core/sdlp_cmd_decode.sv ----
module sdlp_cmd_decode
  import sdlp_pkg::*;
(
  sdlp_cmd_if.dec c
);
  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  // deselect and nop fold together
  wire is_nop = c.cs_n | (c.ras_n & c.cas_n & c.we_n); // RULE_20
  wire is_aref = ~c.cs_n & ~c.ras_n & ~c.cas_n & c.we_n; // RULE_01
  wire is_read = ~c.cs_n & c.ras_n & ~c.cas_n & c.we_n;
  assign c.cmd = is_nop ? SDLP_CMD_NOP :
                 is_aref ? SDLP_CMD_AREF :
                 is_read ? SDLP_CMD_READ : SDLP_CMD_OTHER;
endmodule // sdlp_cmd_decode

// ---- verification/sdlp_ctrl_model.sv ----
// ----------------------------------------------------------------
// memory controller side: turns a small op code into command pins
// ----------------------------------------------------------------
module sdlp_ctrl_model (
  input wire logic cke_req,
  input wire logic [1:0] op_req,
  input wire logic [2:0] junk,
  output logic cke_pin,
  output logic cs_n_pin,
  output logic ras_n_pin,
  output logic cas_n_pin,
  output logic we_n_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // op 0 nop, 1 refresh, 2 deselect; deselect puts junk on the strobes
  // so a decoder that looks past chip select is caught;
  // termination never reaches the block, so it is off all run
  always_comb begin
    cke_pin = cke_req;
    cs_n_pin = (op_req == 2'd2);
    {ras_n_pin, cas_n_pin, we_n_pin} = (op_req == 2'd2) ? junk :
      (op_req == 2'd1) ? 3'b001 : 3'b111;
  end
endmodule // sdlp_ctrl_model

// ---- verification/sdlp_lowpower_tb_top.sv ----
module sdlp_lowpower_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // short counts keep the run brief
  // ----------------------------------------------------------------
  localparam int MP = 4;
  localparam int NR = 2;
  localparam int RD = 10;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic cke_req = 1'b1;
  logic [1:0] op_req = 2'd0;
  logic [2:0] junk = 3'h0;
  logic banks_open = 1'b0;
  logic apd_sel = 1'b0;
  logic cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin;
  logic [9:0] obs;
  logic [19:0] notes[$];
  event sample_ev;
  int n_mismatch = 0;
  int n_checks = 0;

  // clock kept running at one frequency, never halted or changed
  initial begin
    forever #12.5 mclk = ~mclk;
  end

  sdlp_ctrl_model ctrl (.cke_req(cke_req), .op_req(op_req), .junk(junk),
    .cke_pin(cke_pin), .cs_n_pin(cs_n_pin), .ras_n_pin(ras_n_pin),
    .cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin));

  sdlp_lowpower #(.MIN_PULSE_CYC(MP), .NONREAD_CYC(NR), .READ_CYC(RD)) DUT (
    .mclk(mclk), .resetn(resetn), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin),
    .ras_n_pin(ras_n_pin), .cas_n_pin(cas_n_pin), .we_n_pin(we_n_pin),
    .banks_open(banks_open), .active_pd_exit_select(apd_sel),
    .self_refresh_q(obs[9]), .power_down_q(obs[8]), .active_pd_q(obs[7]),
    .dll_enabled_q(obs[6]), .int_clock_gated_q(obs[5]), .buffers_off_q(obs[4]),
    .internal_refresh_q(obs[3]), .cmd_allowed_q(obs[2]), .read_allowed_q(obs[1]),
    .sref_allowed_q(obs[0]));

  // ----------------------------------------------------------------
  // tasks: drive one op for n edges, note and compare outputs
  // ----------------------------------------------------------------
  task automatic drive(input logic cke, input logic [1:0] op, input int n);
    cke_req = cke;
    op_req = op;
    junk = 3'($urandom);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic note(input logic [9:0] e, input logic [9:0] m);
    notes.push_back({e, m});
    -> sample_ev;
  endtask

  // masked compare: an unknown output bit inside the mask never matches
  task automatic cmp(input logic [9:0] e, input logic [9:0] m);
    n_checks++;
    if (((obs ^ e) & m) !== 10'h000) begin
      n_mismatch++;
      $display("CHECK FAILED outputs exp %h got %h mask %h", e, obs, m);
    end
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // monitor takes the oldest note whenever a result is due
  initial begin
    logic [19:0] nt;
    forever begin
      @(sample_ev);
      nt = notes.pop_front();
      cmp(nt[19:10], nt[9:0]);
    end
  end

  // hang guard
  initial begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(31896));
    repeat (20) @(posedge mclk);
    #1 resetn = 1'b1;
    drive(1'b1, 2'd0, 4);
    note(10'h047, 10'h3ff);
    // self-refresh with all banks idle, junk on deselected strobes
    drive(1'b0, 2'd1, 1);
    drive(1'b0, 2'd2, 2);
    note(10'h238, 10'h3ff);
    drive(1'b0, 2'd2, 1);
    note(10'h230, 10'h3ff);
    drive(1'b0, 2'd2, MP + 4);
    note(10'h230, 10'h3ff);
    // exit, nop only until both exit delays have run
    drive(1'b1, 2'd0, 4);
    note(10'h040, 10'h3ff);
    drive(1'b1, 2'd0, 1);
    note(10'h044, 10'h3ff);
    drive(1'b1, 2'd0, RD + 5);
    note(10'h046, 10'h3ff);
    // re-entry without an extra refresh is refused
    drive(1'b0, 2'd1, 1);
    drive(1'b0, 2'd2, 3);
    note(10'h046, 10'h3ff);
    drive(1'b1, 2'd0, 10);
    drive(1'b1, 2'd1, 1);
    drive(1'b1, 2'd0, 8);
    note(10'h047, 10'h3ff);
    // precharge, fast active and slow active power-down
    for (int i = 0; i < 3; i++) begin
      int lat;
      banks_open = (i != 0);
      apd_sel = (i == 2) ? 1'b1 : ((i == 1) ? 1'b0 : 1'($urandom));
      lat = !banks_open ? sdlp_pkg::PD_EXIT_CYC :
            apd_sel ? sdlp_pkg::SLOW_APD_EXIT_CYC : sdlp_pkg::FAST_APD_EXIT_CYC;
      drive(1'b1, 2'd0, 2);
      // no read or write in flight, so entry spacing is already met
      drive(1'b0, (i == 1) ? 2'd0 : 2'd2, 4);
      note({2'b01, banks_open, banks_open & ~apd_sel, 6'h10}, 10'h3ff);
      drive(1'b0, 2'd2, MP);
      note({2'b01, banks_open, banks_open & ~apd_sel, 6'h10}, 10'h3ff);
      drive(1'b1, 2'd0, 4);
      note(10'h000, 10'h3bf);
      drive(1'b1, 2'd0, 1);
      note({7'h00, (lat <= 2), 2'b00}, 10'h004);
      drive(1'b1, 2'd0, 7);
      note(10'h047, 10'h3ff);
    end
    // reset in the middle of self-refresh returns every output to idle
    banks_open = 1'b0;
    drive(1'b0, 2'd1, 1);
    drive(1'b0, 2'd2, 4);
    note(10'h230, 10'h3ff);
    resetn = 1'b0;
    drive(1'b1, 2'd0, 3);
    resetn = 1'b1;
    drive(1'b1, 2'd0, 2);
    note(10'h047, 10'h3ff);
    #1;
    wrap_up();
  end
endmodule // sdlp_lowpower_tb_top
